// ==== sfhb_pkg.sv ====
// Package for the stack alarm and heartbeat block: register map, fields, timing
// Contract
// - With no enabled unmasked alarm, lower tone transmits fixed-rate heartbeat pulses.
// - Any sensed alarm in a group enabled by output select, except the system reset flag bit, stops the heartbeat toward devices below.
// - Masked alarms have no effect on heartbeat generation.
// - Mask only blocks later setting; an already set flag stays set.
// - Unmasked alarm condition sets its bit in the alarm flag registers.
// - Heartbeat comes from own clock; upper tone is never forwarded.
// - Alarm output low on unmasked internal alarm or lost upper tone if monitored.
// - Outside reset and shutdown, alarm output asserts only when host port enable bit is set.
// - Internal groups gated by output select; upper alarms by upper monitor enable.
// - Alarm output low during reset or shutdown.
// - Heartbeat stop and alarm output assertion happen in the same cycle.
// - With stack comms, start needs flag cleared and four upper pulses; clears upstream alarm.
// - Upper monitor watches falling edges; under-frequency sets detect and alarm; one miss tolerated.
// - Over-frequency sets tone rate error; clear succeeds only once signaling is correct.
// - Monitor, auto-sample, command-sample and self-test alarms stop tone and assert output.
// - Tone rate error is evaluated locally in each device.
// - Selected group alarm drives output low and stops tone when enabled.
package sfhb_pkg;
   // Register byte addresses (AXI4-Lite)
   localparam logic [7:0] ADDR_ALARM_SYS = 8'h00;
   localparam logic [7:0] ADDR_ALARM_COM = 8'h04;
   localparam logic [7:0] ADDR_ALARM_DEV = 8'h08;
   localparam logic [7:0] ADDR_SYSTEM_ALARM_MASK = 8'h0c;
   localparam logic [7:0] ADDR_MASK_COM = 8'h10;
   localparam logic [7:0] ADDR_DEVICE_ALARM_MASK = 8'h14;
   localparam logic [7:0] ADDR_OUT_SEL = 8'h18;
   localparam logic [7:0] ADDR_COMM_CFG = 8'h1c;
   localparam logic [7:0] ADDR_STATUS = 8'h20;
   localparam logic [7:0] ADDR_CTRL = 8'h24;
   // Alarm source width per register
   localparam int NSRC = 8;
   // System alarm bits
   localparam int SYSTEM_RESET_FLAG_BIT = 0;
   // Comm alarm bits
   localparam int COM_RATE_ERR_BIT = 0;
   // Output select groups
   localparam int GRP_SYS = 0;
   localparam int GRP_COM = 1;
   localparam int GRP_DEV = 2;
   // Comm config fields
   localparam int CFG_HOST_EN = 0;
   localparam int CFG_UPPER_EN = 1;
   localparam int CFG_STACK_EN = 2;
   // Status fields
   localparam int ST_UP_DET = 0;
   localparam int ST_UP_ALARM = 1;
   localparam int ST_TONE_ON = 2;
   localparam int ST_ALARM_OUT = 3;
   // Control fields
   localparam int CTL_SHUTDOWN = 0;
   // Reset values
   localparam logic [NSRC-1:0] RST_ALARM_SYS = 8'h01;
   localparam logic [NSRC-1:0] RST_MASK = 8'h00;
   localparam logic [NSRC-1:0] RST_OUT_SEL = 8'h07;
   localparam logic [NSRC-1:0] RST_COMM_CFG = 8'h01;
   // Timing at 100 MHz
   localparam int CLK_MHZ = 100;
   localparam int HB_PERIOD_US = 100;
   localparam int HB_PERIOD_CYC = HB_PERIOD_US * CLK_MHZ;
   localparam int HB_WIDTH_CYC = 100;
   localparam int UP_MIN_CYC = HB_PERIOD_CYC / 2;
   localparam int UP_MAX_CYC = HB_PERIOD_CYC * 2 + HB_PERIOD_CYC / 2;
   localparam int START_PULSES = 4;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // Raw alarm conditions from the analog and digital monitors
   typedef struct packed {
      logic [NSRC-1:0] sys;
      logic [NSRC-1:0] com;
      logic [NSRC-1:0] dev;
   } sfhb_cond_s;
endpackage

// ==== sfhb_properties.sv ====
// Checker on the alarm output and heartbeat pins of the alarm block
`timescale 1ns/1ps
module sfhb_properties #(
   parameter int HB_PERIOD = sfhb_pkg::HB_PERIOD_CYC,
   parameter int HB_WIDTH = sfhb_pkg::HB_WIDTH_CYC
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic LOWER_ALARM_TX,
   input wire logic ALARM_OUT_N,
   input wire logic WVALID,
   input wire logic WREADY,
   input wire logic BVALID,
   input wire logic ARVALID,
   input wire logic ARREADY,
   input wire logic RVALID
);
   logic [15:0] gap_r;
   logic [15:0] hi_r;
   logic [7:0] wr_age_r;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // Saturating, so a restart after a long stop never trips the floor
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) gap_r <= 16'hffff;
      else if ($rose(LOWER_ALARM_TX)) gap_r <= 16'h1;
      else if (gap_r != 16'hffff) gap_r <= gap_r + 16'h1;
   end
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) hi_r <= 16'h0;
      else if (LOWER_ALARM_TX) hi_r <= hi_r + 16'h1;
      else hi_r <= 16'h0;
   end
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) wr_age_r <= 8'hff;
      else if (WVALID && WREADY) wr_age_r <= 8'h0;
      else if (wr_age_r != 8'hff) wr_age_r <= wr_age_r + 8'h1;
   end
   sequence s_quiet;
      !ALARM_OUT_N && !LOWER_ALARM_TX;
   endsequence
   a_reset_low: assert property (disable iff (1'b0) !RST_N |-> s_quiet)
      else $error("pins active in reset");
   a_hold_after_reset: assert property ($rose(RST_N) |-> s_quiet [*3])
      else $error("tone before flag cleared");
   a_out_stops_tone: assert property (!ALARM_OUT_N |-> !LOWER_ALARM_TX)
      else $error("tone with output asserted");
   a_pulse_width: assert property (LOWER_ALARM_TX |-> hi_r < HB_WIDTH)
      else $error("pulse too long");
   a_period_floor: assert property ($rose(LOWER_ALARM_TX) |-> gap_r >= HB_PERIOD)
      else $error("pulses too close");
   a_release_write: assert property ($rose(ALARM_OUT_N) |-> wr_age_r != 8'hff)
      else $error("alarm released without write");
   a_read_answer: assert property (ARVALID && ARREADY |-> ##[1:2] RVALID)
      else $error("read answer late");
   a_write_answer: assert property (WVALID && WREADY |-> ##[1:3] BVALID)
      else $error("write answer late");
endmodule
bind sfhb_top sfhb_properties #(.HB_PERIOD(HB_PERIOD), .HB_WIDTH(HB_WIDTH)) u_props (
   .CLK(CLK), .RST_N(RST_N), .LOWER_ALARM_TX(LOWER_ALARM_TX), .ALARM_OUT_N(ALARM_OUT_N),
   .WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID), .ARVALID(ARVALID),
   .ARREADY(ARREADY), .RVALID(RVALID));

// ==== sfhb_tb.sv ====
// Self-checking bench for the stack alarm and heartbeat block
`timescale 1ns/1ps
module testbench;
   import sfhb_pkg::*;
   logic CLK = 1'b0;
   logic RST_N = 1'b1;
   sfhb_cond_s cond = '0;
   logic rx, tx, out_n, awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rr, br;
   logic [31:0] rdata, rd;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic up_run = 1'b1;
   logic [7:0] up_period = 8'h14;
   int bad_count = 0;
   int checks = 0;
   int cyc = 0;
   sfhb_top #(.HB_PERIOD(20), .HB_WIDTH(2), .UP_MIN(10), .UP_MAX(50)) u_dut (
      .CLK(CLK), .RST_N(RST_N), .COND(cond), .UPPER_ALARM_RX(rx), .LOWER_ALARM_TX(tx),
      .ALARM_OUT_N(out_n), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
      .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
      .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
      .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready));
   sfhb_upper_model u_up (.clk(CLK), .run(up_run), .period(up_period), .rx(rx));
   always #5 CLK = ~CLK;
   task automatic finish_test;
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   always @(posedge CLK) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         finish_test;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge CLK);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge CLK);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (!bvalid);
      br = bresp;
      bready <= 1'b0;
   endtask
   task automatic rdr(input logic [7:0] a);
      @(posedge CLK);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge CLK);
         if (arvalid && arready) arvalid <= 1'b0;
      end while (!rvalid);
      rd = rdata;
      rr = rresp;
      rready <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      rdr(a);
      chk(rd & m, e);
   endtask
   task automatic pulses(input int cycles, input int exp);
      int c;
      logic p;
      c = 0;
      p = tx;
      repeat (cycles) begin
         @(posedge CLK);
         if (tx && !p) c++;
         p = tx;
      end
      chk(32'(c), 32'(exp));
   endtask
   task automatic setc(input int g, input int b, input logic v);
      @(posedge CLK);
      cond[(2 - g) * 8 + b] <= v;
   endtask
   task automatic hard_reset;
      RST_N <= 1'b0;
      repeat (5) @(posedge CLK);
      RST_N <= 1'b1;
   endtask
   initial begin
      hard_reset;
      repeat (2) @(posedge CLK);
      chk(32'(out_n), 32'h0);
      rchk(ADDR_ALARM_SYS, 32'hff, 32'h1);
      rchk(ADDR_OUT_SEL, 32'hffffffff, 32'h7);
      rchk(ADDR_COMM_CFG, 32'hffffffff, 32'h1);
      rdr(8'h30);
      chk(32'(rr), 32'(RESP_SLVERR));
      wr(8'h30, 32'h0);
      chk(32'(br), 32'(RESP_SLVERR));
      pulses(40, 0);
      wr(ADDR_ALARM_SYS, 32'h1);
      chk(32'(br), 32'(RESP_OKAY));
      repeat (10) @(posedge CLK);
      pulses(60, 3);
      chk(32'(out_n), 32'h1);
      wr(ADDR_DEVICE_ALARM_MASK, 32'h1);
      setc(GRP_DEV, 0, 1'b1);
      pulses(60, 3);
      rchk(ADDR_ALARM_DEV, 32'hff, 32'h0);
      setc(GRP_DEV, 0, 1'b0);
      for (int g = 0; g < 3; g++) begin
         setc(g, 1, 1'b1);
         repeat (4) @(posedge CLK);
         chk(32'(out_n), 32'h0);
         pulses(40, 0);
         rchk(8'(ADDR_ALARM_SYS + 4 * g), 32'hff, 32'h2);
         wr(8'(ADDR_SYSTEM_ALARM_MASK + 4 * g), 32'h2);
         setc(g, 1, 1'b0);
         rchk(8'(ADDR_ALARM_SYS + 4 * g), 32'hff, 32'h2);
         wr(8'(ADDR_ALARM_SYS + 4 * g), 32'h2);
         wr(8'(ADDR_SYSTEM_ALARM_MASK + 4 * g), 32'h0);
         repeat (3) @(posedge CLK);
         chk(32'(out_n), 32'h1);
      end
      wr(ADDR_OUT_SEL, 32'h3);
      setc(GRP_DEV, 2, 1'b1);
      repeat (4) @(posedge CLK);
      chk(32'(out_n), 32'h1);
      rchk(ADDR_ALARM_DEV, 32'hff, 32'h4);
      setc(GRP_DEV, 2, 1'b0);
      wr(ADDR_ALARM_DEV, 32'h4);
      wr(ADDR_OUT_SEL, 32'h7);
      wr(ADDR_COMM_CFG, 32'h0);
      setc(GRP_SYS, 1, 1'b1);
      repeat (4) @(posedge CLK);
      chk(32'(out_n), 32'h1);
      pulses(40, 0);
      setc(GRP_SYS, 1, 1'b0);
      wr(ADDR_ALARM_SYS, 32'h2);
      wr(ADDR_COMM_CFG, 32'h3);
      // Every other upper pulse missing must pass unflagged
      up_period <= 8'd40;
      repeat (150) @(posedge CLK);
      chk(32'(out_n), 32'h1);
      up_run <= 1'b0;
      repeat (70) @(posedge CLK);
      chk(32'(out_n), 32'h0);
      rchk(ADDR_STATUS, 32'h3, 32'h3);
      up_period <= 8'd20;
      up_run <= 1'b1;
      repeat (60) @(posedge CLK);
      wr(ADDR_STATUS, 32'h3);
      repeat (4) @(posedge CLK);
      chk(32'(out_n), 32'h1);
      up_period <= 8'd6;
      repeat (60) @(posedge CLK);
      rchk(ADDR_ALARM_COM, 32'h1, 32'h1);
      chk(32'(out_n), 32'h0);
      wr(ADDR_ALARM_COM, 32'h1);
      rchk(ADDR_ALARM_COM, 32'h1, 32'h1);
      up_period <= 8'd20;
      repeat (80) @(posedge CLK);
      wr(ADDR_ALARM_COM, 32'h1);
      rchk(ADDR_ALARM_COM, 32'h1, 32'h0);
      wr(ADDR_COMM_CFG, 32'h1);
      wr(ADDR_CTRL, 32'h1);
      repeat (3) @(posedge CLK);
      chk(32'(out_n), 32'h0);
      pulses(40, 0);
      wr(ADDR_CTRL, 32'h0);
      hard_reset;
      up_run <= 1'b0;
      wr(ADDR_COMM_CFG, 32'h5);
      wr(ADDR_ALARM_SYS, 32'h1);
      pulses(40, 0);
      up_run <= 1'b1;
      repeat (110) @(posedge CLK);
      pulses(60, 3);
      chk(32'(out_n), 32'h1);
      rchk(ADDR_STATUS, 32'h2, 32'h0);
      finish_test;
   end
endmodule

// ==== sfhb_top.sv ====
// Stack alarm aggregation, heartbeat generator and upper tone monitor
`timescale 1ns/1ps
module sfhb_top #(
   parameter int HB_PERIOD = sfhb_pkg::HB_PERIOD_CYC,
   parameter int HB_WIDTH = sfhb_pkg::HB_WIDTH_CYC,
   parameter int UP_MIN = sfhb_pkg::UP_MIN_CYC,
   parameter int UP_MAX = sfhb_pkg::UP_MAX_CYC
) (
   input wire logic CLK,
   input wire logic RST_N,
   input wire sfhb_pkg::sfhb_cond_s COND,
   input wire logic UPPER_ALARM_RX,
   output logic LOWER_ALARM_TX,
   output logic ALARM_OUT_N,
   input wire logic [7:0] AWADDR,
   input wire logic AWVALID,
   output logic AWREADY,
   input wire logic [31:0] WDATA,
   input wire logic [3:0] WSTRB,
   input wire logic WVALID,
   output logic WREADY,
   output logic [1:0] BRESP,
   output logic BVALID,
   input wire logic BREADY,
   input wire logic [7:0] ARADDR,
   input wire logic ARVALID,
   output logic ARREADY,
   output logic [31:0] RDATA,
   output logic [1:0] RRESP,
   output logic RVALID,
   input wire logic RREADY
);
   import sfhb_pkg::*;

   typedef enum logic [1:0] {HB_WAIT, HB_RUN, HB_STOP} sfhb_hb_e;

   logic [NSRC-1:0] alarm_sys_r, alarm_com_r, alarm_dev_r;
   logic [NSRC-1:0] system_alarm_mask_r, mask_com_r, device_alarm_mask_r;
   logic [NSRC-1:0] out_sel_r, comm_cfg_r, ctrl_r;
   logic up_det_r, up_alarm_r;
   sfhb_hb_e hb_r;
   logic [31:0] hb_cnt_r;
   logic [31:0] up_cnt_r;
   logic [2:0] up_pulses_r;
   logic up_prev_r;
   logic tone_r, alarm_n_r;
   logic aw_hold_r, w_hold_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r;
   logic [3:0] w_strb_r;
   logic bvalid_r, rvalid_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;

   // Byte-lane merge of the low byte, the only one that carries register bits
   function automatic logic [NSRC-1:0] merge(input logic [NSRC-1:0] old,
                                             input logic [31:0] d,
                                             input logic [3:0] s);
      merge = s[0] ? d[NSRC-1:0] : old;
   endfunction

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a <= ADDR_CTRL) && (a[1:0] == 2'b00);
   endfunction

   // Write channel: address and data taken in either order
   logic wr_go;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   assign wr_go = aw_hold_r && w_hold_r && !bvalid_r;
   assign wr_addr = aw_addr_r;
   assign wr_data = w_data_r;
   assign wr_strb = w_strb_r;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         aw_hold_r <= 1'b0;
         aw_addr_r <= 8'h00;
      end else if (AWVALID && AWREADY) begin
         aw_hold_r <= 1'b1;
         aw_addr_r <= AWADDR;
      end else if (wr_go) begin
         aw_hold_r <= 1'b0;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         w_hold_r <= 1'b0;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
      end else if (WVALID && WREADY) begin
         w_hold_r <= 1'b1;
         w_data_r <= WDATA;
         w_strb_r <= WSTRB;
      end else if (wr_go) begin
         w_hold_r <= 1'b0;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         AWREADY <= 1'b0;
         WREADY <= 1'b0;
      end else begin
         AWREADY <= !aw_hold_r && !(AWVALID && AWREADY) && !bvalid_r;
         WREADY <= !w_hold_r && !(WVALID && WREADY) && !bvalid_r;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_r <= 1'b1;
         bresp_r <= is_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (BREADY) begin
         bvalid_r <= 1'b0;
      end
   end

   // Read channel, one outstanding read
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ARREADY <= 1'b0;
      end else begin
         ARREADY <= !rvalid_r && !(ARVALID && ARREADY);
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rvalid_r <= 1'b0;
         rresp_r <= RESP_OKAY;
         rdata_r <= 32'h0000_0000;
      end else if (ARVALID && ARREADY) begin
         rvalid_r <= 1'b1;
         rresp_r <= is_mapped(ARADDR) ? RESP_OKAY : RESP_SLVERR;
         case (ARADDR)
            ADDR_ALARM_SYS: rdata_r <= {24'h000000, alarm_sys_r};
            ADDR_ALARM_COM: rdata_r <= {24'h000000, alarm_com_r};
            ADDR_ALARM_DEV: rdata_r <= {24'h000000, alarm_dev_r};
            ADDR_SYSTEM_ALARM_MASK: rdata_r <= {24'h000000, system_alarm_mask_r};
            ADDR_MASK_COM: rdata_r <= {24'h000000, mask_com_r};
            ADDR_DEVICE_ALARM_MASK: rdata_r <= {24'h000000, device_alarm_mask_r};
            ADDR_OUT_SEL: rdata_r <= {24'h000000, out_sel_r};
            ADDR_COMM_CFG: rdata_r <= {24'h000000, comm_cfg_r};
            ADDR_STATUS: rdata_r <= {28'h0000000, ~alarm_n_r, tone_r, up_alarm_r, up_det_r};
            ADDR_CTRL: rdata_r <= {24'h000000, ctrl_r};
            default: rdata_r <= 32'h0000_0000;
         endcase
      end else if (RREADY) begin
         rvalid_r <= 1'b0;
      end
   end

   logic wr_hit_sys, wr_hit_com, wr_hit_dev, wr_hit_st;
   assign wr_hit_sys = wr_go && wr_addr == ADDR_ALARM_SYS && wr_strb[0];
   assign wr_hit_com = wr_go && wr_addr == ADDR_ALARM_COM && wr_strb[0];
   assign wr_hit_dev = wr_go && wr_addr == ADDR_ALARM_DEV && wr_strb[0];
   assign wr_hit_st = wr_go && wr_addr == ADDR_STATUS && wr_strb[0];

   // Plain settings
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         system_alarm_mask_r <= RST_MASK;
         mask_com_r <= RST_MASK;
         device_alarm_mask_r <= RST_MASK;
         out_sel_r <= RST_OUT_SEL;
         comm_cfg_r <= RST_COMM_CFG;
         ctrl_r <= 8'h00;
      end else if (wr_go) begin
         case (wr_addr)
            ADDR_SYSTEM_ALARM_MASK: system_alarm_mask_r <= merge(system_alarm_mask_r, wr_data, wr_strb);
            ADDR_MASK_COM: mask_com_r <= merge(mask_com_r, wr_data, wr_strb);
            ADDR_DEVICE_ALARM_MASK: device_alarm_mask_r <= merge(device_alarm_mask_r, wr_data, wr_strb);
            ADDR_OUT_SEL: out_sel_r <= merge(out_sel_r, wr_data, wr_strb);
            ADDR_COMM_CFG: comm_cfg_r <= merge(comm_cfg_r, wr_data, wr_strb);
            ADDR_CTRL: ctrl_r <= merge(ctrl_r, wr_data, wr_strb);
            default: ;
         endcase
      end
   end

   // Upper tone monitor: falling edges only
   logic up_fall, up_under, up_over, up_rate_bad;
   assign up_fall = up_prev_r && !UPPER_ALARM_RX;
   // Two periods plus margin: one lost pulse passes unreported
   assign up_under = comm_cfg_r[CFG_UPPER_EN] && (up_cnt_r >= 32'(UP_MAX));
   assign up_over = comm_cfg_r[CFG_UPPER_EN] && up_fall && (up_cnt_r < 32'(UP_MIN));
   // Rate still wrong means the error cannot be cleared yet
   assign up_rate_bad = up_over || (comm_cfg_r[CFG_UPPER_EN] && up_pulses_r == 3'd0);

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         up_prev_r <= 1'b0;
         up_cnt_r <= 32'h0000_0000;
         up_pulses_r <= 3'd0;
      end else begin
         up_prev_r <= UPPER_ALARM_RX;
         if (up_fall) begin
            up_cnt_r <= 32'h0000_0000;
            if (up_over || up_under) begin
               up_pulses_r <= 3'd0;
            end else if (up_pulses_r < 3'(START_PULSES)) begin
               up_pulses_r <= up_pulses_r + 3'd1;
            end
         end else begin
            if (up_cnt_r < 32'(UP_MAX)) begin
               up_cnt_r <= up_cnt_r + 32'h0000_0001;
            end
            if (up_under) begin
               up_pulses_r <= 3'd0;
            end
         end
      end
   end

   // Flags: set wins over clear; mask gates only new sets
   logic [NSRC-1:0] set_sys, set_com, set_dev;
   assign set_sys = COND.sys & ~system_alarm_mask_r;
   assign set_com = (COND.com | {{(NSRC-1){1'b0}}, up_over}) & ~mask_com_r;
   assign set_dev = COND.dev & ~device_alarm_mask_r;

   // Write-one-to-clear, applied before the set term so a new event wins
   function automatic logic [NSRC-1:0] w1c(input logic [NSRC-1:0] old,
                                           input logic hit,
                                           input logic [31:0] d);
      w1c = hit ? (old & ~d[NSRC-1:0]) : old;
   endfunction

   // Rate error held while the tone rate is still wrong
   logic [NSRC-1:0] keep_com;
   assign keep_com = {{(NSRC-1){1'b0}}, alarm_com_r[COM_RATE_ERR_BIT] & up_rate_bad};

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         alarm_sys_r <= RST_ALARM_SYS;
      end else begin
         alarm_sys_r <= w1c(alarm_sys_r, wr_hit_sys, wr_data) | set_sys;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         alarm_com_r <= 8'h00;
      end else begin
         alarm_com_r <= w1c(alarm_com_r, wr_hit_com, wr_data) | set_com | keep_com;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         alarm_dev_r <= 8'h00;
      end else begin
         alarm_dev_r <= w1c(alarm_dev_r, wr_hit_dev, wr_data) | set_dev;
      end
   end

   logic start_ok;
   assign start_ok = !alarm_sys_r[SYSTEM_RESET_FLAG_BIT]
                     && (!comm_cfg_r[CFG_STACK_EN] || up_pulses_r == 3'(START_PULSES));

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         up_det_r <= 1'b0;
         up_alarm_r <= 1'b0;
      end else begin
         if (up_under) begin
            up_det_r <= 1'b1;
            up_alarm_r <= 1'b1;
         end else begin
            if (wr_hit_st && wr_data[ST_UP_DET]) begin
               up_det_r <= 1'b0;
            end
            if (hb_r == HB_WAIT && start_ok) begin
               up_alarm_r <= 1'b0;
            end else if (wr_hit_st && wr_data[ST_UP_ALARM]) begin
               up_alarm_r <= 1'b0;
            end
         end
      end
   end

   // Output select gating of groups
   logic int_alarm, up_lost, trip;
   assign int_alarm = (out_sel_r[GRP_SYS] && |alarm_sys_r[NSRC-1:1])
                      || (out_sel_r[GRP_COM] && |alarm_com_r)
                      || (out_sel_r[GRP_DEV] && |alarm_dev_r);
   assign up_lost = comm_cfg_r[CFG_UPPER_EN] && up_alarm_r;
   // One term drives both outputs so they switch on the same edge
   assign trip = int_alarm || up_lost || ctrl_r[CTL_SHUTDOWN];

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         hb_r <= HB_WAIT;
         hb_cnt_r <= 32'h0000_0000;
      end else begin
         case (hb_r)
            HB_WAIT: begin
               hb_cnt_r <= 32'h0000_0000;
               if (start_ok && !trip) begin
                  hb_r <= HB_RUN;
               end
            end
            HB_RUN: begin
               if (trip) begin
                  hb_r <= HB_STOP;
               end else if (hb_cnt_r == 32'(HB_PERIOD - 1)) begin
                  hb_cnt_r <= 32'h0000_0000;
               end else begin
                  hb_cnt_r <= hb_cnt_r + 32'h0000_0001;
               end
            end
            HB_STOP: begin
               hb_cnt_r <= 32'h0000_0000;
               if (!trip) begin
                  hb_r <= HB_WAIT;
               end
            end
            default: hb_r <= HB_WAIT;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         tone_r <= 1'b0;
      end else begin
         tone_r <= hb_r == HB_RUN && !trip && hb_cnt_r < 32'(HB_WIDTH);
      end
   end

   // Shutdown forces the pin low even with the host port disabled
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         alarm_n_r <= 1'b0;
      end else begin
         alarm_n_r <= !((trip || hb_r != HB_RUN) && comm_cfg_r[CFG_HOST_EN])
                      && !ctrl_r[CTL_SHUTDOWN];
      end
   end

   assign LOWER_ALARM_TX = tone_r;
   assign ALARM_OUT_N = alarm_n_r;
   assign BVALID = bvalid_r;
   assign BRESP = bresp_r;
   assign RVALID = rvalid_r;
   assign RRESP = rresp_r;
   assign RDATA = rdata_r;
endmodule

// ==== sfhb_upper_model.sv ====
// Upper neighbour: its own heartbeat, one falling edge per period
`timescale 1ns/1ps
module sfhb_upper_model (
   input wire logic clk,
   input wire logic run,
   input wire logic [7:0] period,
   output logic rx
);
   logic [7:0] cnt_r = 8'h00;
   initial rx = 1'b1;
   always_ff @(posedge clk) begin
      if (!run || cnt_r >= period - 8'h1) cnt_r <= 8'h00;
      else cnt_r <= cnt_r + 8'h01;
   end
   // Stopped tone idles high, so no falling edge is ever seen
   always @(posedge clk) begin
      rx <= !run || cnt_r >= 8'h02;
   end
endmodule
